// ---- src/cps_pkg.sv ----
// constants and field layout shared by the power and calibration setup block
package cps_pkg;
	// clock and time base
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int FP_PERIOD_MS = 36;
	localparam int FP_PERIOD_CYC = FP_PERIOD_MS * CYC_PER_MS;
	localparam int LP_STEP_MS = 200;
	localparam int LP_STEP_CYC = LP_STEP_MS * CYC_PER_MS;
	localparam int TMR_W = 26;

	// register addressing over the serial link
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam logic [10:0] REG_PWR_ADDR = 11'h000;
	localparam logic [10:0] REG_CAL_ADDR = 11'h001;
	localparam logic [15:0] PWR_RST_VAL = 16'h0000;
	localparam logic [15:0] CAL_RST_VAL = 16'h0000;
	// bit 13 of the power register is not stored and the self-clearing bit 10 never is
	localparam logic [15:0] PWR_WMASK = 16'hDBFF;

	// power_setup_register fields
	localparam int MODE_LSB = 0;
	localparam int LPW_LSB = 2;
	localparam int STG_LSB = 4;
	localparam int DEC_LSB = 8;
	localparam int SWRST_BIT = 10;
	localparam int IRQPOL_BIT = 11;
	localparam int EXC_BIT = 12;
	localparam int BIAS_LSB = 14;

	// stage_calibration_enable fields
	localparam int N_CAL_STAGES = 8;
	localparam int FPSKIP_LSB = 12;
	localparam int LPSKIP_LSB = 14;

	// operating mode codes, the two remaining codes mean shutdown
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_LOW = 2'h2;

	// decimation ratios
	localparam int DEC_W = 9;
	localparam logic [8:0] DECIM_256 = 9'h100;
	localparam logic [8:0] DECIM_128 = 9'h080;
	localparam logic [8:0] DECIM_64 = 9'h040;

	// sample skip counts
	localparam int SKIP_W = 5;
	localparam logic [4:0] FP_SKIP_0 = 5'h03;
	localparam logic [4:0] FP_SKIP_1 = 5'h07;
	localparam logic [4:0] FP_SKIP_2 = 5'h0F;
	localparam logic [4:0] FP_SKIP_3 = 5'h1F;
	localparam logic [4:0] LP_SKIP_0 = 5'h00;
	localparam logic [4:0] LP_SKIP_1 = 5'h01;
	localparam logic [4:0] LP_SKIP_2 = 5'h02;
	localparam logic [4:0] LP_SKIP_3 = 5'h03;

	// stages per sequence
	localparam int STAGE_W = 4;
	localparam logic [3:0] STAGE_MAX_CODE = 4'hB;
endpackage : cps_pkg

// ---- src/cps_reg_if.sv ----
// register access channel between the serial link and the register bank
`timescale 1ns/1ps
interface cps_reg_if;
	logic wr;
	logic [10:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport link (output wr, output addr, output wdata, input rdata);
	modport bank (input wr, input addr, input wdata, output rdata);
endinterface : cps_reg_if

// ---- src/cps_conv_timer.sv ----
// interval timer that paces conversion sequences
`timescale 1ns/1ps
module cps_conv_timer #(
	parameter int W = 26
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic [W-1:0] i_period,
	output logic o_tick
);
	logic [W-1:0] count_q;

	// count while running, wrap after i_period cycles and pulse tick once
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_q <= '0;
			o_tick <= 1'b0;
		end else if (i_clear) begin
			count_q <= '0;
			o_tick <= 1'b0;
		end else if (i_run && count_q == i_period - W'(1)) begin
			count_q <= '0;
			o_tick <= 1'b1;
		end else begin
			count_q <= i_run ? count_q + W'(1) : count_q;
			o_tick <= 1'b0;
		end
	end
endmodule : cps_conv_timer

// ---- src/cps_i2c_link.sv ----
// two-wire serial slave giving the host access to the register bank
`timescale 1ns/1ps
module cps_i2c_link #(
	parameter logic [6:0] DEV_ADDR = 7'h2C
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	cps_reg_if.link bus
);
	import cps_pkg::*;

	typedef enum logic [2:0] {LK_IDLE, LK_RECV, LK_ACK, LK_SEND, LK_RACK} cps_lk_t;

	cps_lk_t state_q;
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	logic [2:0] bit_q;
	logic [7:0] shift_q, hold_q;
	logic full_q, is_dev_q, rw_q, rd_lo_q, inc_q, wr_q;
	logic [1:0] wph_q;
	logic [10:0] ptr_q;
	logic [15:0] wdata_q;
	logic scl_rise, scl_fall, start_w, stop_w;

	// two-flop synchronisers, the third stage only feeds edge detection
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{scl_m, scl_s, scl_p} <= 3'h7;
			{sda_m, sda_s, sda_p} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_p} <= {i_scl, scl_m, scl_s};
			{sda_m, sda_s, sda_p} <= {i_sda, sda_m, sda_s};
		end
	end

	assign scl_rise = scl_s && !scl_p;
	assign scl_fall = !scl_s && scl_p;
	assign start_w = scl_s && scl_p && sda_p && !sda_s;
	assign stop_w = scl_s && scl_p && !sda_p && sda_s;
	// open drain: the pin is only ever pulled low
	assign o_sda_out = 1'b0;
	assign bus.wr = wr_q;
	assign bus.addr = ptr_q;
	assign bus.wdata = wdata_q;

	// byte engine: address byte, pointer bytes, then data words high byte first
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= LK_IDLE;
			bit_q <= '0;
			shift_q <= '0;
			hold_q <= '0;
			full_q <= 1'b0;
			is_dev_q <= 1'b0;
			rw_q <= 1'b0;
			rd_lo_q <= 1'b0;
			inc_q <= 1'b0;
			wr_q <= 1'b0;
			wph_q <= '0;
			ptr_q <= '0;
			wdata_q <= '0;
			o_sda_oe <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (start_w) begin
				state_q <= LK_RECV;
				bit_q <= '0;
				full_q <= 1'b0;
				is_dev_q <= 1'b1;
				wph_q <= '0;
				o_sda_oe <= 1'b0;
			end else if (stop_w) begin
				state_q <= LK_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				case (state_q)
					LK_RECV: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], sda_s};
							bit_q <= bit_q + 3'h1;
							full_q <= (bit_q == 3'h7);
						end else if (scl_fall && full_q) begin
							full_q <= 1'b0;
							if (is_dev_q) begin
								is_dev_q <= 1'b0;
								rw_q <= shift_q[0];
								rd_lo_q <= 1'b0;
								state_q <= (shift_q[7:1] == DEV_ADDR) ? LK_ACK : LK_IDLE;
								o_sda_oe <= (shift_q[7:1] == DEV_ADDR);
							end else begin
								state_q <= LK_ACK;
								o_sda_oe <= 1'b1;
								wph_q <= (wph_q == 2'h3) ? 2'h2 : wph_q + 2'h1;
								case (wph_q)
									2'h0: ptr_q[10:8] <= shift_q[2:0];
									2'h1: ptr_q[7:0] <= shift_q;
									2'h2: hold_q <= shift_q;
									default: begin
										wr_q <= 1'b1;
										wdata_q <= {hold_q, shift_q};
										inc_q <= 1'b1;
									end
								endcase
							end
						end
					end
					LK_ACK: begin
						if (scl_fall) begin
							bit_q <= '0;
							if (rw_q) begin
								state_q <= LK_SEND;
								shift_q <= bus.rdata[15:8];
								o_sda_oe <= !bus.rdata[15];
							end else begin
								state_q <= LK_RECV;
								o_sda_oe <= 1'b0;
							end
							if (inc_q) begin
								ptr_q <= ptr_q + 11'h001;
								inc_q <= 1'b0;
							end
						end
					end
					LK_SEND: begin
						if (scl_fall) begin
							if (bit_q == 3'h7) begin
								state_q <= LK_RACK;
								o_sda_oe <= 1'b0;
							end else begin
								shift_q <= {shift_q[6:0], 1'b0};
								o_sda_oe <= !shift_q[6];
								bit_q <= bit_q + 3'h1;
							end
						end
					end
					LK_RACK: begin
						// a word is done once its low byte is acknowledged
						if (scl_rise) begin
							if (sda_s) begin
								state_q <= LK_IDLE;
							end else if (rd_lo_q) begin
								ptr_q <= ptr_q + 11'h001;
							end
						end else if (scl_fall) begin
							state_q <= LK_SEND;
							bit_q <= '0;
							rd_lo_q <= !rd_lo_q;
							shift_q <= rd_lo_q ? bus.rdata[15:8] : bus.rdata[7:0];
							o_sda_oe <= rd_lo_q ? !bus.rdata[15] : !bus.rdata[7];
						end
					end
					default: begin
						state_q <= LK_IDLE;
					end
				endcase
			end
		end
	end
endmodule : cps_i2c_link

// ---- src/cps_power_setup.sv ----
// power, sequencing and calibration setup registers with conversion pacing
`timescale 1ns/1ps

module cps_power_setup #(
	parameter int FP_CYC = cps_pkg::FP_PERIOD_CYC,
	parameter int LP_STEP = cps_pkg::LP_STEP_CYC,
	parameter logic [6:0] DEV_ADDR = 7'h2C
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_irq_req,
	input wire logic i_stage_done,
	output logic o_int_pin,
	output logic o_seq_start,
	output logic o_seq_done,
	output logic o_stage_req,
	output logic [cps_pkg::STAGE_W-1:0] o_stage_idx,
	output logic o_stage_cal,
	output logic [cps_pkg::STAGE_W-1:0] o_stage_total,
	output logic [cps_pkg::N_CAL_STAGES-1:0] o_cal_en,
	output logic o_low_power,
	output logic o_shutdown,
	output logic o_excite_en,
	output logic [1:0] o_bias_sel,
	output logic [cps_pkg::DEC_W-1:0] o_decim_ratio,
	output logic [cps_pkg::SKIP_W-1:0] o_skip_count
);
	import cps_pkg::*;

	typedef enum logic {SQ_IDLE, SQ_RUN} cps_sq_t;

	cps_reg_if bus ();
	cps_sq_t sq_q;
	logic [15:0] pwr_q, cal_q, rdata_q;
	logic [1:0] mode_w, mode_prev_q, lpw_prev_q;
	logic is_fp, is_lp, is_off, soft_rst, tmr_clear, tmr_run, tick;
	logic [3:0] last_stage;
	logic [TMR_W-1:0] period_w;
	logic cal_bit_w;

	// host side of the register bank
	cps_i2c_link #(.DEV_ADDR(DEV_ADDR)) u_link (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe),
		.bus(bus.link)
	);

	assign soft_rst = bus.wr && bus.addr == REG_PWR_ADDR && bus.wdata[SWRST_BIT];

	// writes never depend on the operating mode
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pwr_q <= PWR_RST_VAL;
			cal_q <= CAL_RST_VAL;
		end else if (soft_rst) begin
			pwr_q <= PWR_RST_VAL;
			cal_q <= CAL_RST_VAL;
		end else if (bus.wr && bus.addr == REG_PWR_ADDR) begin
			pwr_q <= bus.wdata & PWR_WMASK;
		end else if (bus.wr && bus.addr == REG_CAL_ADDR) begin
			cal_q <= bus.wdata;
		end
	end

	// registered read data; unmapped addresses read zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= (bus.addr == REG_PWR_ADDR) ? pwr_q : (bus.addr == REG_CAL_ADDR) ? cal_q : 16'h0000;
		end
	end
	assign bus.rdata = rdata_q;

	assign mode_w = pwr_q[MODE_LSB +: 2];
	assign is_fp = mode_w == MODE_FULL;
	assign is_lp = mode_w == MODE_LOW;
	assign is_off = !is_fp && !is_lp;
	// codes above twelve stages are clamped to the legal maximum
	assign last_stage = (pwr_q[STG_LSB +: 4] > STAGE_MAX_CODE) ? STAGE_MAX_CODE : pwr_q[STG_LSB +: 4];

	// wait grows in equal steps with the field code
	assign period_w = is_lp ? TMR_W'(LP_STEP * (int'(pwr_q[LPW_LSB +: 2]) + 1)) : TMR_W'(FP_CYC);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_prev_q <= PWR_RST_VAL[MODE_LSB +: 2];
			lpw_prev_q <= PWR_RST_VAL[LPW_LSB +: 2];
		end else begin
			mode_prev_q <= mode_w;
			lpw_prev_q <= pwr_q[LPW_LSB +: 2];
		end
	end

	// low power restarts the wait at sequence end and holds it while busy
	assign tmr_clear = soft_rst || is_off || mode_w != mode_prev_q || pwr_q[LPW_LSB +: 2] != lpw_prev_q
		|| (is_lp && o_seq_done);
	assign tmr_run = is_fp || (is_lp && sq_q == SQ_IDLE);

	cps_conv_timer #(.W(TMR_W)) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(tmr_clear),
		.i_run(tmr_run),
		.i_period(period_w),
		.o_tick(tick)
	);

	// stage walk; a tick that arrives mid-sequence is dropped
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sq_q <= SQ_IDLE;
			o_stage_idx <= '0;
			o_stage_req <= 1'b0;
			o_seq_start <= 1'b0;
			o_seq_done <= 1'b0;
		end else begin
			o_seq_start <= 1'b0;
			o_seq_done <= 1'b0;
			case (sq_q)
				SQ_IDLE: begin
					if (tick && !is_off && !soft_rst) begin
						sq_q <= SQ_RUN;
						o_stage_idx <= '0;
						o_stage_req <= 1'b1;
						o_seq_start <= 1'b1;
					end
				end
				SQ_RUN: begin
					// shutdown aborts a sequence in flight
					if (is_off || soft_rst) begin
						sq_q <= SQ_IDLE;
						o_stage_req <= 1'b0;
					end else if (i_stage_done) begin
						if (o_stage_idx >= last_stage) begin
							sq_q <= SQ_IDLE;
							o_stage_req <= 1'b0;
							o_seq_done <= 1'b1;
						end else begin
							o_stage_idx <= o_stage_idx + 4'h1;
						end
					end
				end
				default: begin
					sq_q <= SQ_IDLE;
					o_stage_req <= 1'b0;
				end
			endcase
		end
	end

	// only the first eight stages own a calibration enable
	assign cal_bit_w = (o_stage_idx < STAGE_W'(N_CAL_STAGES)) ? cal_q[o_stage_idx[2:0]] : 1'b0;

	// static decode of the setup fields onto registered outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int_pin <= 1'b1;
			o_stage_cal <= 1'b0;
			o_stage_total <= 4'h1;
			o_cal_en <= '0;
			o_low_power <= 1'b0;
			o_shutdown <= 1'b0;
			o_excite_en <= 1'b1;
			o_bias_sel <= '0;
			o_decim_ratio <= DECIM_256;
			o_skip_count <= FP_SKIP_0;
		end else begin
			// active level follows the polarity bit
			o_int_pin <= pwr_q[IRQPOL_BIT] ? i_irq_req : !i_irq_req;
			// calibration enable for the stage in progress
			o_stage_cal <= cal_bit_w;
			o_cal_en <= cal_q[N_CAL_STAGES-1:0];
			o_stage_total <= last_stage + 4'h1;
			o_low_power <= is_lp;
			o_shutdown <= is_off;
			o_excite_en <= !pwr_q[EXC_BIT];
			// bias step is passed on as its code
			o_bias_sel <= pwr_q[BIAS_LSB +: 2];
			case (pwr_q[DEC_LSB +: 2])
				2'h0: o_decim_ratio <= DECIM_256;
				2'h1: o_decim_ratio <= DECIM_128;
				default: o_decim_ratio <= DECIM_64;
			endcase
			// skip count of the mode in force
			case ({is_lp, cal_q[(is_lp ? LPSKIP_LSB : FPSKIP_LSB) +: 2]})
				3'h0: o_skip_count <= FP_SKIP_0;
				3'h1: o_skip_count <= FP_SKIP_1;
				3'h2: o_skip_count <= FP_SKIP_2;
				3'h3: o_skip_count <= FP_SKIP_3;
				3'h4: o_skip_count <= LP_SKIP_0;
				3'h5: o_skip_count <= LP_SKIP_1;
				3'h6: o_skip_count <= LP_SKIP_2;
				default: o_skip_count <= LP_SKIP_3;
			endcase
		end
	end

	// helper: cycles since the pacing timer was last cleared or ticked
	logic [TMR_W-1:0] gap_q;
	logic armed_q, from_clr_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gap_q <= '0;
			armed_q <= 1'b0;
			from_clr_q <= 1'b0;
		end else if (tmr_clear || tick) begin
			gap_q <= '0;
			armed_q <= !is_off;
			from_clr_q <= tmr_clear;
		end else if (tmr_run) begin
			gap_q <= gap_q + TMR_W'(1);
		end
	end

	sequence s_last_done;
		o_stage_req && i_stage_done && o_stage_idx == last_stage && !is_off && !soft_rst;
	endsequence
	sequence s_seq_closed;
		o_seq_done && !o_stage_req ##1 !o_seq_done;
	endsequence

	a_fp_period: assert property (@(posedge i_clk) disable iff (i_rst)
		tick && is_fp && armed_q && !tmr_clear |-> gap_q == TMR_W'(from_clr_q ? FP_CYC : FP_CYC - 1))
		else $error("full power pacing period wrong");
	a_off_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		is_off |=> !o_seq_start && !o_stage_req)
		else $error("conversion activity during shutdown");
	a_lp_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		is_lp |=> o_low_power && !o_shutdown)
		else $error("low power mode not reported");
	a_lp_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		tick && is_lp && armed_q && from_clr_q && !tmr_clear |-> gap_q == period_w)
		else $error("low power wait not as selected");
	a_lp_gap: assert property (@(posedge i_clk) disable iff (i_rst)
		is_lp && o_seq_done |-> !o_seq_start [*8])
		else $error("low power sequence restarted without waiting");
	a_stage_count: assert property (@(posedge i_clk) disable iff (i_rst)
		s_last_done |=> s_seq_closed)
		else $error("sequence did not close on its last stage");
	a_decim_map: assert property (@(posedge i_clk) disable iff (i_rst)
		pwr_q[DEC_LSB +: 2] == 2'h3 |=> o_decim_ratio == DECIM_64)
		else $error("decimation code 3 not mapped to 64");
	a_soft_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		soft_rst |=> pwr_q == PWR_RST_VAL && cal_q == CAL_RST_VAL ##2 !bus.rdata[SWRST_BIT])
		else $error("soft reset did not restore defaults");
	a_irq_polarity: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 o_int_pin == ($past(pwr_q[IRQPOL_BIT]) ~^ $past(i_irq_req)))
		else $error("interrupt pin level wrong for polarity");
	a_excite_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(pwr_q[EXC_BIT]) |=> !o_excite_en)
		else $error("excitation still driven when disabled");
	a_bias_sel: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 o_bias_sel == $past(pwr_q[BIAS_LSB +: 2]))
		else $error("bias selection not passed on");
	a_stage_cal: assert property (@(posedge i_clk) disable iff (i_rst)
		o_stage_req && o_stage_idx >= STAGE_W'(N_CAL_STAGES) |=> !o_stage_cal)
		else $error("calibration enabled for a stage without enable bit");
	a_fp_skip: assert property (@(posedge i_clk) disable iff (i_rst)
		!is_lp && cal_q[FPSKIP_LSB +: 2] == 2'h3 |=> o_skip_count == FP_SKIP_3)
		else $error("full power skip count wrong");
	a_lp_skip: assert property (@(posedge i_clk) disable iff (i_rst)
		is_lp && cal_q[LPSKIP_LSB +: 2] == 2'h0 |=> o_skip_count == LP_SKIP_0)
		else $error("low power skip count wrong");
	a_off_access: assert property (@(posedge i_clk) disable iff (i_rst)
		is_off && bus.wr && bus.addr == REG_CAL_ADDR |=> cal_q == $past(bus.wdata))
		else $error("register write lost during shutdown");
endmodule : cps_power_setup

// ---- verification/cps_host_model.sv ----
// host processor model that reaches the register bank over the two-wire link
`timescale 1ns/1ps
module cps_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2C
) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// half of hp is one quarter bit; raise hp to act as a slow host
	int hp = 10;
	int nack_cnt = 0;
	// o_sda high means released, the pull-up then gives 1
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic qw();
		repeat (hp / 2) @(negedge i_clk);
	endtask : qw
	// data moves only while the clock line is low
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		qw();
		o_scl = 1'b1;
		qw();
		r = i_sda;
		qw();
		o_scl = 1'b0;
		qw();
	endtask : bit_io
	// start and repeated start: data falls while the clock is high
	task automatic start();
		o_sda = 1'b1;
		qw();
		o_scl = 1'b1;
		repeat (2) qw();
		o_sda = 1'b0;
		repeat (2) qw();
		o_scl = 1'b0;
		qw();
	endtask : start
	task automatic stop();
		o_sda = 1'b0;
		qw();
		o_scl = 1'b1;
		repeat (2) qw();
		o_sda = 1'b1;
		repeat (2) qw();
	endtask : stop
	// a missing acknowledge is counted, the bench checks the count
	task automatic send(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		if (r !== 1'b0) begin
			nack_cnt++;
		end
	endtask : send
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask : recv
	// d0, and d1 too when n exceeds 1, from pointer a, high byte first
	task automatic wr(input logic [10:0] a, input logic [15:0] d0, input logic [15:0] d1, input int n);
		start();
		send({DEV_ADDR, 1'b0});
		send({5'h00, a[10:8]});
		send(a[7:0]);
		send(d0[15:8]);
		send(d0[7:0]);
		if (n > 1) begin
			send(d1[15:8]);
			send(d1[7:0]);
		end
		stop();
	endtask : wr
	task automatic rd(input logic [10:0] a, output logic [15:0] v);
		start();
		send({DEV_ADDR, 1'b0});
		send({5'h00, a[10:8]});
		send(a[7:0]);
		start();
		send({DEV_ADDR, 1'b1});
		recv(1'b0, v[15:8]);
		recv(1'b1, v[7:0]);
		stop();
	endtask : rd
endmodule : cps_host_model

// ---- verification/tb_cps_power_setup.sv ----
// self-checking bench for the power and calibration setup block
`timescale 1ns/1ps
module tb_cps_power_setup;
	import cps_pkg::*;
	localparam int FP = 40;
	localparam int LPS = 30;
	localparam logic [15:0] PV [4] = '{16'h0000, 16'h41B1, 16'h9A3E, 16'hC3F3};
	localparam logic [15:0] CV [4] = '{16'h003C, 16'h5081, 16'hA0FF, 16'hF000};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic irq_req = 1'b0;
	logic stage_done = 1'b0;
	logic scl, sda_host, sda_w, sda_out, sda_oe, int_pin, seq_start, seq_done, stage_req;
	logic low_power, shutdown, excite_en;
	logic [1:0] bias_sel;
	logic [3:0] stage_total;
	logic [7:0] cal_en;
	logic [8:0] decim;
	logic [4:0] skip;
	logic [3:0] stage_idx;
	logic stage_cal;
	// stage 0 is never recorded: its enable lags the index and still shows the previous sequence
	logic [15:0] calseen = 16'h0000;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	int ndone = 0;
	int t0, t1, n;
	// open-drain data wire with pull-up
	assign sda_w = sda_host & (sda_oe ? sda_out : 1'b1);
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// converter stand-in: finishes a stage every other cycle, counts stages and records calibration
	always @(negedge clk) begin
		stage_done <= (stage_req === 1'b1) && !stage_done;
		ndone <= ((seq_start === 1'b1) ? 0 : ndone) + int'((stage_req === 1'b1) && !stage_done);
		if (seq_start === 1'b1) begin
			calseen <= 16'h0000;
		end else if ((stage_req === 1'b1) && !stage_done) begin
			calseen[stage_idx] <= stage_cal;
		end
	end
	cps_host_model #(.DEV_ADDR(7'h2C)) u_cps_host_model (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_host));
	cps_power_setup #(.FP_CYC(FP), .LP_STEP(LPS), .DEV_ADDR(7'h2C)) u_cps_power_setup (
		.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_irq_req(irq_req), .i_stage_done(stage_done), .o_int_pin(int_pin), .o_seq_start(seq_start),
		.o_seq_done(seq_done), .o_stage_req(stage_req), .o_stage_idx(stage_idx), .o_stage_cal(stage_cal),
		.o_stage_total(stage_total), .o_cal_en(cal_en), .o_low_power(low_power), .o_shutdown(shutdown),
		.o_excite_en(excite_en), .o_bias_sel(bias_sel), .o_decim_ratio(decim), .o_skip_count(skip));
	function automatic logic [31:0] stat();
		return {9'h000, low_power, shutdown, excite_en, bias_sel, stage_total, decim, skip};
	endfunction : stat
	// expected decoded outputs worked out from the two register words
	function automatic logic [31:0] exp_stat(input logic [15:0] p, input logic [15:0] c);
		logic [8:0] dec;
		logic [4:0] sk;
		logic [3:0] st;
		logic lp;
		lp = (p[1:0] == 2'h2);
		dec = (p[9:8] == 2'h0) ? 9'h100 : ((p[9:8] == 2'h1) ? 9'h080 : 9'h040);
		sk = lp ? {3'h0, c[15:14]} : ((5'h04 << c[13:12]) - 5'h01);
		st = (p[7:4] > 4'hA) ? 4'hC : p[7:4] + 4'h1;
		return {9'h000, lp, p[0], ~p[12], p[15:14], st, dec, sk};
	endfunction : exp_stat
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("ERROR t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_rng
	task automatic w(input logic [10:0] a, input logic [15:0] d);
		u_cps_host_model.wr(a, d, 16'h0000, 1);
	endtask : w
	task automatic rchk(input logic [10:0] a, input logic [15:0] e);
		logic [15:0] got;
		u_cps_host_model.rd(a, got);
		chk({16'h0000, got}, {16'h0000, e});
	endtask : rchk
	// bounded wait for a sequence start (0) or end (1), returns the cycle number
	task automatic wait_hi(input int which, output int at);
		int k;
		k = 0;
		while (((which == 0) ? seq_start : seq_done) !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > 3000) begin
				n_fail++;
				$display("ERROR t=%0t sequence event missing", $time);
				print_verdict();
			end
		end
		at = cyc;
		@(negedge clk);
	endtask : wait_hi
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk(stat(), exp_stat(16'h0000, 16'h0000));
		rchk(REG_PWR_ADDR, PWR_RST_VAL);
		rchk(REG_CAL_ADDR, CAL_RST_VAL);
		// first bulk write leaves the calibration word at zero, enables come last
		u_cps_host_model.wr(REG_PWR_ADDR, 16'h00B2, 16'h0000, 2);
		w(REG_CAL_ADDR, 16'h00FF);
		rchk(REG_PWR_ADDR, 16'h00B2);
		chk(stat(), exp_stat(16'h00B2, 16'h00FF));
		// every code of mode, decimation and bias, stage count codes 0, 3, 11 and 15, full power skip codes 0, 1 and 3
		for (int i = 0; i < 4; i++) begin
			u_cps_host_model.wr(REG_PWR_ADDR, PV[i], CV[i], 2);
			rchk(REG_PWR_ADDR, PV[i]);
			rchk(REG_CAL_ADDR, CV[i]);
			chk(stat(), exp_stat(PV[i], CV[i]));
			chk({24'h000000, cal_en}, {24'h000000, CV[i][7:0]});
		end
		w(REG_PWR_ADDR, 16'h0002);
		for (int k = 0; k < 4; k++) begin
			w(REG_CAL_ADDR, {k[1:0], 14'h0000});
			chk(stat(), exp_stat(16'h0002, {k[1:0], 14'h0000}));
		end
		// interrupt pin level for both polarities and both request states
		for (int p = 0; p < 2; p++) begin
			w(REG_PWR_ADDR, {4'h0, p[0], 11'h000});
			for (int r = 0; r < 2; r++) begin
				irq_req = r[0];
				repeat (3) @(negedge clk);
				chk({31'h0, int_pin}, {31'h0, ~(r[0] ^ p[0])});
			end
		end
		irq_req = 1'b0;
		// full power: four stages, free-running period
		w(REG_PWR_ADDR, 16'h0030);
		wait_hi(0, t0);
		wait_hi(1, t1);
		chk_rng(ndone, 4, 4);
		wait_hi(0, t1);
		chk_rng(t1 - t0, FP, FP);
		// clamped code gives twelve stages; stages 8 to 11 own no enable and must not pick up a low bit
		w(REG_CAL_ADDR, 16'h005A);
		w(REG_PWR_ADDR, 16'h00F0);
		wait_hi(0, t0);
		wait_hi(1, t1);
		chk_rng(ndone, 12, 12);
		chk({16'h0000, calseen}, 32'h0000005A);
		// low power: wait from sequence end to next start for each delay code
		for (int k = 0; k < 4; k++) begin
			w(REG_PWR_ADDR, {12'h000, k[1:0], 2'h2});
			wait_hi(1, t0);
			wait_hi(0, t1);
			chk_rng(t1 - t0, LPS * (k + 1), LPS * (k + 1) + 2);
		end
		// shutdown: nothing starts, registers stay reachable, even by a slow host
		w(REG_PWR_ADDR, 16'h0001);
		repeat (4) @(negedge clk);
		n = 0;
		repeat (300) begin
			@(negedge clk);
			n += int'(seq_start === 1'b1);
		end
		chk_rng(n, 0, 0);
		chk({31'h0, stage_req}, 32'h0);
		u_cps_host_model.hp = 40;
		w(REG_CAL_ADDR, 16'h3055);
		rchk(REG_CAL_ADDR, 16'h3055);
		u_cps_host_model.hp = 10;
		// soft reset clears both words and reads back zero
		w(REG_PWR_ADDR, 16'h04B2);
		rchk(REG_PWR_ADDR, 16'h0000);
		rchk(REG_CAL_ADDR, 16'h0000);
		chk(stat(), exp_stat(16'h0000, 16'h0000));
		// unmapped place: write ignored, read gives zero
		w(11'h005, 16'hBEEF);
		rchk(11'h005, 16'h0000);
		chk_rng(u_cps_host_model.nack_cnt, 0, 0);
		print_verdict();
	end
endmodule : tb_cps_power_setup
